// ==== logic/spx_regs.vh ====
// Constants for the serial port expander access logic.
`ifndef SPX_REGS_VH
`define SPX_REGS_VH

// Fixed upper address bits for the two port groups.
`define SPX_PFX_A       3'h6
`define SPX_PFX_B       3'h5

// Bits in a byte on the wire.
`define SPX_BYTE_BITS   4'h8

// Position of the four open-drain ports within group A.
`define SPX_OD_LSB      2
`define SPX_OD_MSB      5

// Output latch values after reset.
`define SPX_A_RESET     8'hFF
`define SPX_B_RESET     8'hFF

`endif

// ==== logic/spx_sync.v ====
// Two flip-flop synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none

module spx_sync #(
    parameter W = 22
) (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_q;
    reg [W-1:0] stab_q;

    // =====================================================================
    // Synchroniser stages
    // The first stage feeds only the second one.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b1}};
            stab_q <= {W{1'b1}};
        end else begin
            meta_q <= d;
            stab_q <= meta_q;
        end
    end

    assign q = stab_q;

endmodule

`default_nettype wire

// ==== logic/spx_core.v ====
// Slave access logic of a two-wire serial port expander with two port groups.
`timescale 1ns/1ns
`default_nettype none
`include "spx_regs.vh"

module spx_core (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    input  wire [1:0] addr_select_low,
    input  wire [1:0] addr_select_high,
    output wire       alert_n_out,
    output wire       alert_n_oe,
    input  wire [7:0] grp_a_pin_in,
    output wire [7:0] grp_a_latch,
    output wire [3:0] open_drain_io_ports_oe,
    input  wire [7:0] grp_b_pin_in,
    output wire [7:0] push_pull_group_b_outputs
);

    // =====================================================================
    // State encoding
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ADDR = 7'h02;
    localparam [6:0] S_AACK = 7'h04;
    localparam [6:0] S_WR   = 7'h08;
    localparam [6:0] S_WACK = 7'h10;
    localparam [6:0] S_RD   = 7'h20;
    localparam [6:0] S_MACK = 7'h40;

    // =====================================================================
    // Input synchronisation
    wire [21:0] sync_w;
    wire        scl_s;
    wire        sda_s;
    wire [7:0]  pin_a_s;
    wire [7:0]  pin_b_s;
    wire [3:0]  adr_s;

    // All pins pass two flip-flops before any logic reads them.
    spx_sync #(
        .W (22)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       ({addr_select_high, addr_select_low, grp_b_pin_in,
                   grp_a_pin_in, sda_in, scl_in}),
        .q       (sync_w)
    );

    assign scl_s   = sync_w[0];
    assign sda_s   = sync_w[1];
    assign pin_a_s = sync_w[9:2];
    assign pin_b_s = sync_w[17:10];
    assign adr_s   = sync_w[21:18];

    // =====================================================================
    // Bus line edge and condition detection
    reg scl_p_q;
    reg sda_p_q;

    // Previous synchronised levels of the two bus lines.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    wire scl_rise;
    wire scl_fall;
    wire bus_start;
    wire bus_stop;

    // START and STOP are data edges while the clock stays high.
    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // =====================================================================
    // Transfer state
    reg [6:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] rx_q;
    reg [7:0] tx_q;
    reg       rd_q;
    reg       grp_b_q;
    reg       flag_byte_q;
    reg       mack_ok_q;
    reg       sda_oe_q;
    reg [7:0] a_lat_q;
    reg [7:0] b_lat_q;

    // Sampled port data, flag copy, transition baseline and change flags.
    reg [7:0] snap_q;
    reg [3:0] fcopy_q;
    reg [3:0] base_q;
    reg [3:0] flags_q;
    reg       hold_q;
    reg       alert_oe_q;

    wire addr_hit_a;
    wire addr_hit_b;

    // Match the received address against both group addresses.
    assign addr_hit_a = (rx_q[7:1] == {`SPX_PFX_A, adr_s});
    assign addr_hit_b = (rx_q[7:1] == {`SPX_PFX_B, adr_s});

    wire aack_rise;
    wire mack_rise;
    wire samp_a;
    wire samp_b;
    wire flag_clr;

    // Port sampling instants: the address acknowledge, then each master acknowledge for group B, but for group A only the one after a flag byte.
    assign aack_rise = scl_rise & (st_q == S_AACK);
    assign mack_rise = scl_rise & (st_q == S_MACK);
    assign samp_a    = aack_rise & ~grp_b_q;
    assign samp_b    = (aack_rise | mack_rise) & grp_b_q;
    assign flag_clr  = samp_a | (mack_rise & ~grp_b_q & flag_byte_q);

    // =====================================================================
    // Bus protocol state machine
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= S_IDLE;
            bit_q       <= 4'h0;
            rx_q        <= 8'h00;
            tx_q        <= 8'h00;
            rd_q        <= 1'b0;
            grp_b_q     <= 1'b0;
            flag_byte_q <= 1'b0;
            mack_ok_q   <= 1'b0;
            sda_oe_q    <= 1'b0;
            a_lat_q     <= `SPX_A_RESET;
            b_lat_q     <= `SPX_B_RESET;
        end else if (bus_start) begin
            st_q     <= S_ADDR;
            bit_q    <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (bus_stop) begin
            st_q     <= S_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                S_ADDR: begin
                    if (scl_rise) begin
                        rx_q  <= {rx_q[6:0], sda_s};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == `SPX_BYTE_BITS) begin
                        if (addr_hit_a || addr_hit_b) begin
                            sda_oe_q <= 1'b1;          // Acknowledge own address.
                            st_q     <= S_AACK;
                            rd_q     <= rx_q[0];
                            grp_b_q  <= addr_hit_b;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        if (rd_q) begin
                            tx_q        <= snap_q;
                            sda_oe_q    <= ~snap_q[7];
                            bit_q       <= 4'h1;
                            flag_byte_q <= 1'b0;
                            st_q        <= S_RD;
                        end else begin
                            sda_oe_q <= 1'b0;
                            bit_q    <= 4'h0;
                            st_q     <= S_WR;
                        end
                    end
                end
                S_WR: begin
                    if (scl_rise) begin
                        rx_q  <= {rx_q[6:0], sda_s};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == `SPX_BYTE_BITS) begin
                        sda_oe_q <= 1'b1;
                        st_q     <= S_WACK;
                        // The whole byte replaces the group's latches at once.
                        if (grp_b_q) begin
                            b_lat_q <= rx_q;
                        end else begin
                            a_lat_q <= rx_q;
                        end
                    end
                end
                S_WACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        bit_q    <= 4'h0;
                        st_q     <= S_WR;
                    end
                end
                S_RD: begin
                    if (scl_fall) begin
                        if (bit_q == `SPX_BYTE_BITS) begin
                            sda_oe_q <= 1'b0;          // Let the master acknowledge.
                            st_q     <= S_MACK;
                        end else begin
                            tx_q     <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= ~tx_q[6];
                            bit_q    <= bit_q + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        mack_ok_q <= ~sda_s;
                    end else if (scl_fall) begin
                        if (mack_ok_q) begin
                            bit_q <= 4'h1;
                            st_q  <= S_RD;
                            // Group A alternates port and flag bytes.
                            if (!grp_b_q && !flag_byte_q) begin
                                tx_q        <= {2'h0, fcopy_q, 2'h0};
                                sda_oe_q    <= 1'b1;
                                flag_byte_q <= 1'b1;
                            end else begin
                                tx_q        <= snap_q;
                                sda_oe_q    <= ~snap_q[7];
                                flag_byte_q <= 1'b0;
                            end
                        end else begin
                            st_q <= S_IDLE;            // No acknowledge ends the read.
                        end
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // Port snapshot and transition detection
    wire [3:0] od_now;
    wire [3:0] diff_w;

    assign od_now = pin_a_s[`SPX_OD_MSB:`SPX_OD_LSB];
    assign diff_w = od_now ^ base_q;

    // Snapshots come from the pins, so forced levels are reported as seen.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_q  <= 8'h00;
            fcopy_q <= 4'h0;
            base_q  <= 4'h0;
            flags_q <= 4'h0;
        end else begin
            if (samp_b) begin
                snap_q <= pin_b_s;
            end else if (flag_clr) begin
                snap_q <= pin_a_s;
            end
            if (flag_clr) begin
                // A change in this very cycle lands in the copy, not lost.
                fcopy_q <= flags_q | diff_w;
                base_q  <= od_now;
                flags_q <= 4'h0;
            end else begin
                flags_q <= flags_q | diff_w;
            end
        end
    end

    // =====================================================================
    // Change alert control
    reg       hold_d;
    reg [3:0] flags_d;

    // Alert is held off from the group A address acknowledge until STOP.
    always @* begin
        hold_d  = hold_q;
        flags_d = flags_q | diff_w;
        if (bus_stop) begin
            hold_d = 1'b0;
        end else if (samp_a) begin
            hold_d = 1'b1;
        end
        if (flag_clr) begin
            flags_d = 4'h0;
        end
    end

    // Alert drives low whenever flags are pending and it is not held off.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q     <= 1'b0;
            alert_oe_q <= 1'b0;
        end else begin
            hold_q     <= hold_d;
            alert_oe_q <= (|flags_d) & ~hold_d;
        end
    end

    // =====================================================================
    // Pin drivers
    genvar i;

    // Each open-drain port pulls low while its latch bit is zero.
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_od
            assign open_drain_io_ports_oe[i] = ~a_lat_q[`SPX_OD_LSB + i];
        end
    endgenerate

    assign sda_out                   = 1'b0;
    assign sda_oe                    = sda_oe_q;
    assign alert_n_out               = 1'b0;
    assign alert_n_oe                = alert_oe_q;
    assign grp_a_latch               = a_lat_q;
    assign push_pull_group_b_outputs = b_lat_q;

endmodule

`default_nettype wire

// ==== testbench/spx_master.sv ====
// Behavioural two-wire bus master that drives the expander's serial pins.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bus master model
module spx_master (
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda_pull
);
    // The clock stands high and the data line is released between frames.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Waits a number of system clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One bit of 160 ns: data moves mid-low and is read mid-high.
    task automatic bitx(input logic b, output logic r);
        tick(4);
        sda_pull <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(4);
        r = sda_line;
        tick(4);
        scl <= 1'b0;
    endtask
    // Data falls while the clock is high to open a frame.
    task automatic start();
        sda_pull <= 1'b1;
        tick(8);
        scl <= 1'b0;
    endtask
    // Data rises while the clock is high to close a frame.
    task automatic stop();
        tick(4);
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_pull <= 1'b0;
        tick(8);
    endtask
    // Sends a byte most significant bit first and returns the acknowledge.
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    // Reads a byte, then acknowledges it or not.
    task automatic rbyte(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(~ack, r);
    endtask
    // Address byte: group prefix, select nibble, then the direction bit.
    task automatic addr(input logic [2:0] pfx, input logic [3:0] sel, input logic rd,
                        output logic ack);
        wbyte({pfx, sel, rd}, ack);
    endtask
endmodule
`default_nettype wire

// ==== testbench/spx_core_props.sv ====
// Concurrent checks on the ports of the expander access logic.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Checker
module spx_core_props (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [1:0] addr_select_low,
    input wire logic [1:0] addr_select_high,
    input wire logic       alert_n_out,
    input wire logic       alert_n_oe,
    input wire logic [7:0] grp_a_pin_in,
    input wire logic [7:0] grp_a_latch,
    input wire logic [3:0] open_drain_io_ports_oe,
    input wire logic [7:0] grp_b_pin_in,
    input wire logic [7:0] push_pull_group_b_outputs
);
    logic scl_p_q;
    logic sda_p_q;
    logic in_xfer_q;
    logic rel_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Frame tracking from raw bus conditions, and alert release within a frame.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            in_xfer_q <= 1'b0;
            rel_q <= 1'b0;
        end else begin
            scl_p_q <= scl_in;
            sda_p_q <= sda_in;
            if (scl_p_q && scl_in && sda_p_q && !sda_in) begin
                in_xfer_q <= 1'b1;
            end else if (scl_p_q && scl_in && !sda_p_q && sda_in) begin
                in_xfer_q <= 1'b0;
            end
            if (!in_xfer_q) begin
                rel_q <= 1'b0;
            end else if ($fell(alert_n_oe)) begin
                rel_q <= 1'b1;
            end
        end
    end
    // An acknowledge or data bit driven at a clock rise holds for four system clock cycles from that rise.
    sequence s_drive_at_rise;
        $rose(scl_in) ##0 sda_oe;
    endsequence
    sequence s_drive_held;
        sda_oe [*4];
    endsequence
    AST_ALERT_HELD: assert property (rel_q |-> !alert_n_oe)
        else $error("alert reasserted before the frame ended");
    AST_ACK_STANDS: assert property (s_drive_at_rise |-> s_drive_held)
        else $error("data line released while the clock was high");
    AST_SDA_MOVES_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line changed while the clock was high");
    AST_SDA_IDLE: assert property (!in_xfer_q |-> !sda_oe)
        else $error("data line driven outside a frame");
    AST_B_LATCH_FRAME: assert property ($changed(push_pull_group_b_outputs) |-> in_xfer_q)
        else $error("group B outputs changed outside a frame");
    AST_A_LATCH_FRAME: assert property ($changed(grp_a_latch) |-> in_xfer_q)
        else $error("group A latch changed outside a frame");
    AST_LATCH_AT_FALL: assert property (
        $changed(push_pull_group_b_outputs) || $changed(grp_a_latch)
        |-> !scl_in && !$past(scl_in, 3))
        else $error("output latch changed away from a clock fall");
    AST_OD_FOLLOW: assert property (open_drain_io_ports_oe == ~grp_a_latch[5:2])
        else $error("open-drain enables differ from the latch");
    AST_PINS_LOW: assert property (!sda_out && !alert_n_out)
        else $error("open-drain data value not low");
endmodule
bind spx_core spx_core_props i_props (
    .ref_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_select_low,
    .addr_select_high, .alert_n_out, .alert_n_oe, .grp_a_pin_in, .grp_a_latch,
    .open_drain_io_ports_oe, .grp_b_pin_in, .push_pull_group_b_outputs
);
`default_nettype wire

// ==== testbench/serial_port_expander_access_tb.sv ====
// Self-checking testbench of the expander access logic.
`timescale 1ns/1ns
`default_nettype none
`include "spx_regs.vh"
// ==========================================================
// Testbench
module serial_port_expander_access_tb;
    localparam logic [3:0] SEL = 4'h9;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] grp_a_pin_in = 8'h24;
    logic [7:0] grp_b_pin_in = 8'hFF;
    logic [7:0] force_mask = 8'h00;
    wire        scl;
    wire        sda_pull;
    wire        sda_out;
    wire        sda_oe;
    wire        alert_n_out;
    wire        alert_n_oe;
    wire  [7:0] grp_a_latch;
    wire  [3:0] od_oe;
    wire  [7:0] pp_out;
    wire        sda_line = ~(sda_pull | (sda_oe & ~sda_out));
    int         err_count = 0;
    int         n_tests = 0;
    int         cyc = 0;
    logic       a;
    logic [7:0] d;
    spx_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_low(2'h1),
        .addr_select_high(2'h2), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
        .grp_a_pin_in(grp_a_pin_in), .grp_a_latch(grp_a_latch),
        .open_drain_io_ports_oe(od_oe), .grp_b_pin_in(grp_b_pin_in),
        .push_pull_group_b_outputs(pp_out));
    spx_master i_master (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));
    // Clock, group B pins with forced bits, and the hang limit.
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        grp_b_pin_in <= pp_out ^ force_mask;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (err_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Wrong prefix and wrong select nibble are both ignored.
    task automatic t_refuse();
        i_master.start();
        i_master.addr(3'h7, SEL, 1'b0, a);
        chk(a, 1'b0);
        i_master.stop();
        i_master.start();
        i_master.addr(`SPX_PFX_A, 4'h6, 1'b1, a);
        chk(a, 1'b0);
        i_master.stop();
        chk(alert_n_oe, 1'b1);
    endtask
    // Two-byte group B write; alert left asserted.
    task automatic t_write_b();
        i_master.start();
        i_master.addr(`SPX_PFX_B, SEL, 1'b0, a);
        chk(a, 1'b1);
        i_master.wbyte(8'hA5, a);
        chk({a, pp_out[6:0]}, 8'hA5);
        i_master.wbyte(8'h5A, a);
        chk(a, 1'b1);
        chk(pp_out, 8'h5A);
        chk(alert_n_oe, 1'b1);
        i_master.stop();
    endtask
    // Group B reads the pins, fresh at every acknowledge.
    task automatic t_read_b();
        force_mask <= 8'h81;
        i_master.start();
        i_master.addr(`SPX_PFX_B, SEL, 1'b1, a);
        chk(a, 1'b1);
        force_mask <= 8'h00;
        i_master.rbyte(d, 1'b1);
        chk(d, 8'hDB);
        i_master.rbyte(d, 1'b0);
        chk(d, 8'h5A);
        i_master.stop();
    endtask
    // Two-byte group A read: port byte, flag byte, flags cleared after.
    task automatic t_read_a2();
        i_master.start();
        i_master.addr(`SPX_PFX_A, SEL, 1'b1, a);
        chk(alert_n_oe, 1'b0);
        i_master.rbyte(d, 1'b1);
        chk(d, 8'h24);
        i_master.rbyte(d, 1'b0);
        // The baseline resets to zero while the synchroniser resets to ones, so all four flags are set.
        chk(d, 8'h3C);
        i_master.stop();
        i_master.tick(20);
        chk(alert_n_oe, 1'b0);
        // Lowering one open-drain I/O flags only that port.
        grp_a_pin_in <= 8'h20;
        i_master.tick(10);
        chk(alert_n_oe, 1'b1);
        // A three-byte read returns port, flags, then a fresh port byte.
        i_master.start();
        i_master.addr(`SPX_PFX_A, SEL, 1'b1, a);
        i_master.rbyte(d, 1'b1);
        chk(d, 8'h20);
        i_master.rbyte(d, 1'b1);
        chk(d, 8'h04);
        i_master.rbyte(d, 1'b0);
        chk(d, 8'h20);
        i_master.stop();
        i_master.tick(20);
        chk(alert_n_oe, 1'b0);
    endtask
    // One-byte group A read with a pin change while the byte is shifted.
    task automatic t_read_a1();
        i_master.start();
        i_master.addr(`SPX_PFX_A, SEL, 1'b1, a);
        grp_a_pin_in <= 8'h24;
        i_master.rbyte(d, 1'b0);
        chk(d, 8'h20);
        chk(alert_n_oe, 1'b0);
        i_master.stop();
        i_master.tick(20);
        chk(alert_n_oe, 1'b1);
    endtask
    // Group A write releases the alert and sets a mix of ports.
    task automatic t_write_a();
        i_master.start();
        i_master.addr(`SPX_PFX_A, SEL, 1'b0, a);
        chk(alert_n_oe, 1'b0);
        i_master.wbyte(8'h0F, a);
        chk(a, 1'b1);
        chk(grp_a_latch, 8'h0F);
        chk(od_oe, 4'hC);
        i_master.stop();
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        i_master.tick(30);
        t_refuse();
        t_write_b();
        t_read_b();
        t_read_a2();
        t_read_a1();
        t_write_a();
        close_out();
    end
endmodule
`default_nettype wire
